//--- rtl/sads_sequencer.sv
`timescale 1ns/100ps
// Functional notes
// - each 16-bit word goes out on the bus to two 8-bit latches
// - frame strobe fall drops track/hold and starts a conversion
// - frame strobe runs at 31.25 kHz and paces all sequencing
// - comparator sampled after each trial to pick next value
// - sixteen trials per conversion, each with its own strobe
// - strobe spacing shrinks for the later, smaller trial steps
// - seventeenth strobe latches the left output word
// - left gate rises after the left word has settled
// - last strobe of the frame latches the right output word
// - right gate rises after the right latch
// - cpu clock is the master clock divided by four
module sads_sequencer
	import sads_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	// analog side
	input  wire logic              i_comparator_in,
	// output words from the audio core
	input  wire sads_words_s       i_out_words,
	// converter pins
	output logic [WORD_W-1:0]      o_digital_audio_bus,
	output sads_pins_s             o_pins,
	output logic                   o_frame_strobe_n,
	output logic                   o_cpu_clock,
	// conversion result
	output logic [WORD_W-1:0]      o_sample_word,
	output logic                   o_sample_valid
);

	localparam logic [7:0] STROBE_LOAD = 8'(STROBE_CYC - 1);
	localparam logic [7:0] LONG_LOAD   = 8'(SETTLE_LONG_CYC - 1);
	localparam logic [7:0] SHORT_LOAD  = 8'(SETTLE_SHORT_CYC - 1);
	localparam logic [7:0] OUT_LOAD    = 8'(OUT_SETTLE_CYC - 1);

	function automatic logic [WORD_W-1:0] trial_mask(input logic [4:0] phase);
		return 16'h8000 >> phase[3:0];
	endfunction

	function automatic logic [7:0] settle_load(input logic [4:0] phase);
		if (phase >= NUM_TRIALS) begin
			return OUT_LOAD;
		end
		return (phase < PHASE_SHORT) ? LONG_LOAD : SHORT_LOAD;
	endfunction

	logic frame_tick;

	sads_timebase u_timebase (
		.i_clk            (i_clk),
		.i_arst_n         (i_arst_n),
		.o_frame_strobe_n (o_frame_strobe_n),
		.o_frame_tick     (frame_tick),
		.o_cpu_clock      (o_cpu_clock)
	);

	// -----------------------------------------------------------------
	// sequencer state
	// -----------------------------------------------------------------
	sads_state_e       state;
	sads_state_e       next_state;
	logic [4:0]        phase;
	logic [4:0]        next_phase;
	logic [7:0]        wait_cnt;
	logic [7:0]        next_wait_cnt;
	logic [WORD_W-1:0] sar;
	logic [WORD_W-1:0] next_sar;
	sads_words_s       held;
	sads_words_s       next_held;
	logic [WORD_W-1:0] next_bus;
	sads_pins_s        next_pins;
	logic [WORD_W-1:0] next_sample_word;
	logic              next_sample_valid;

	always_comb begin
		next_state        = state;
		next_phase        = phase;
		next_wait_cnt     = wait_cnt;
		next_sar          = sar;
		next_held         = held;
		next_bus          = o_digital_audio_bus;
		next_pins         = o_pins;
		next_sample_word  = o_sample_word;
		next_sample_valid = 1'b0;
		// a frame edge always restarts; the full sequence fits well inside a frame
		if (frame_tick) begin
			next_pins.track_hold_ctl = 1'b0;
			// right output holds before the first trial moves the dac
			next_pins.right_output_gate = 1'b0;
			next_held  = i_out_words;
			next_sar   = WORD_ZERO;
			next_phase = PHASE_ZERO;
			next_state = ST_SETUP;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_SETUP: begin
					// bus changes only here, a full cycle before the strobe rises
					if (phase == PHASE_LEFT) begin
						next_bus = held.left;
						next_pins.left_output_gate = 1'b0;
					end else if (phase == PHASE_RIGHT) begin
						next_bus = held.right;
						next_pins.right_output_gate = 1'b0;
						// left output holds before the dac takes the right word
						next_pins.left_output_gate = 1'b0;
					end else begin
						next_bus = sar | trial_mask(phase);
					end
					next_wait_cnt = STROBE_LOAD;
					next_state    = ST_STROBE;
				end
				ST_STROBE: begin
					next_pins.conv_latch_strobe = 1'b1;
					if (wait_cnt == WAIT_ZERO) begin
						next_wait_cnt = settle_load(phase);
						next_state    = ST_SETTLE;
					end else begin
						next_wait_cnt = wait_cnt - 8'h01;
					end
				end
				ST_SETTLE: begin
					next_pins.conv_latch_strobe = 1'b0;
					if (wait_cnt == WAIT_ZERO) begin
						next_state = ST_DECIDE;
					end else begin
						next_wait_cnt = wait_cnt - 8'h01;
					end
				end
				ST_DECIDE: begin
					next_state = ST_SETUP;
					next_phase = phase + 5'h01;
					if (phase == PHASE_RIGHT) begin
						next_pins.right_output_gate = 1'b1;
						next_state = ST_IDLE;
					end else if (phase == PHASE_LEFT) begin
						next_pins.left_output_gate = 1'b1;
					end else begin
						// comparator high: input above trial level, keep the bit
						if (i_comparator_in) begin
							next_sar = o_digital_audio_bus;
						end
						if (phase == NUM_TRIALS - 5'h01) begin
							next_sample_word  = i_comparator_in ? o_digital_audio_bus : sar;
							next_sample_valid = 1'b1;
							next_pins.track_hold_ctl = 1'b1;
						end
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state               <= ST_IDLE;
			phase               <= PHASE_ZERO;
			wait_cnt            <= WAIT_ZERO;
			sar                 <= WORD_ZERO;
			held                <= '0;
			o_digital_audio_bus <= WORD_ZERO;
			o_pins              <= PINS_RESET;
			o_sample_word       <= WORD_ZERO;
			o_sample_valid      <= 1'b0;
		end else begin
			state               <= next_state;
			phase               <= next_phase;
			wait_cnt            <= next_wait_cnt;
			sar                 <= next_sar;
			held                <= next_held;
			o_digital_audio_bus <= next_bus;
			o_pins              <= next_pins;
			o_sample_word       <= next_sample_word;
			o_sample_valid      <= next_sample_valid;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	localparam logic [7:0] LONG_GAP  = 8'(STROBE_CYC + SETTLE_LONG_CYC + 2);
	localparam logic [7:0] SHORT_GAP = 8'(STROBE_CYC + SETTLE_SHORT_CYC + 2);

	logic [4:0] strobes_seen;
	logic [7:0] gap;
	logic       strobe_prev;
	wire        strobe_rise = o_pins.conv_latch_strobe && !strobe_prev;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strobes_seen <= PHASE_ZERO;
			gap          <= WAIT_ZERO;
			strobe_prev  <= 1'b0;
		end else begin
			strobe_prev <= o_pins.conv_latch_strobe;
			if ($fell(o_frame_strobe_n)) begin
				strobes_seen <= PHASE_ZERO;
			end else if (strobe_rise) begin
				strobes_seen <= strobes_seen + 5'h01;
			end
			gap <= strobe_rise ? 8'h01 : gap + 8'h01;
		end
	end

	property p_hold_on_frame;
		@(posedge i_clk) disable iff (!i_arst_n)
		$fell(o_frame_strobe_n) |=> !o_pins.track_hold_ctl;
	endproperty
	a_hold_on_frame: assert property (p_hold_on_frame) else $error("no hold at frame");

	property p_sixteen_trials;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_sample_valid |-> (strobes_seen == NUM_TRIALS) && o_pins.track_hold_ctl;
	endproperty
	a_sixteen_trials: assert property (p_sixteen_trials) else $error("trial count wrong");

	property p_bus_stable;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_pins.conv_latch_strobe |-> $stable(o_digital_audio_bus);
	endproperty
	a_bus_stable: assert property (p_bus_stable) else $error("bus moved under strobe");

	property p_left_latch;
		@(posedge i_clk) disable iff (!i_arst_n)
		(strobe_rise && strobes_seen == PHASE_LEFT) |->
			(o_digital_audio_bus == held.left) && !o_pins.left_output_gate;
	endproperty
	a_left_latch: assert property (p_left_latch) else $error("left latch wrong");

	property p_right_latch;
		@(posedge i_clk) disable iff (!i_arst_n)
		(strobe_rise && strobes_seen == PHASE_RIGHT) |->
			(o_digital_audio_bus == held.right) && !o_pins.right_output_gate;
	endproperty
	a_right_latch: assert property (p_right_latch) else $error("right latch wrong");

	property p_left_gate;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_pins.left_output_gate) |-> (strobes_seen == PHASE_RIGHT) &&
			(gap == 8'(STROBE_CYC + OUT_SETTLE_CYC));
	endproperty
	a_left_gate: assert property (p_left_gate) else $error("left gate early");

	property p_right_gate;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_pins.right_output_gate) |-> (strobes_seen == 5'h12) && (state == ST_IDLE);
	endproperty
	a_right_gate: assert property (p_right_gate) else $error("right gate wrong");

	property p_short_steps;
		@(posedge i_clk) disable iff (!i_arst_n)
		(strobe_rise && strobes_seen > PHASE_ZERO && strobes_seen < NUM_TRIALS + 5'h01) |->
			(gap == ((strobes_seen <= PHASE_SHORT) ? LONG_GAP : SHORT_GAP));
	endproperty
	a_short_steps: assert property (p_short_steps) else $error("strobe spacing wrong");

	property p_hold_release;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_pins.track_hold_ctl) |-> o_sample_valid;
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("hold released early");

endmodule

//--- rtl/sads_timebase.sv
`timescale 1ns/100ps
module sads_timebase
	import sads_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// timing outputs
	output logic      o_frame_strobe_n,
	output logic      o_frame_tick,
	output logic      o_cpu_clock
);

	localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYCLES - 1);
	localparam logic [11:0] FRAME_LOW  = 12'(FRAME_LOW_CYC);
	localparam logic [1:0]  CPU_LAST   = 2'(CPU_DIV - 1);
	localparam logic [1:0]  CPU_HALF   = 2'(CPU_DIV / 2);

	logic [11:0] frame_cnt;
	logic [11:0] next_frame_cnt;
	logic [1:0]  cpu_cnt;
	logic [1:0]  next_cpu_cnt;
	logic        next_frame_strobe_n;
	logic        next_frame_tick;
	logic        next_cpu_clock;

	always_comb begin
		next_frame_cnt      = (frame_cnt == FRAME_LAST) ? 12'h000 : frame_cnt + 12'h001;
		next_frame_tick     = (next_frame_cnt == 12'h000);
		next_frame_strobe_n = !(next_frame_cnt < FRAME_LOW);
		next_cpu_cnt        = (cpu_cnt == CPU_LAST) ? 2'h0 : cpu_cnt + 2'h1;
		next_cpu_clock      = (next_cpu_cnt >= CPU_HALF);
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			// start past the low phase so the first fall comes with a tick
			frame_cnt        <= FRAME_LOW;
			cpu_cnt          <= 2'h0;
			o_frame_strobe_n <= 1'b1;
			o_frame_tick     <= 1'b0;
			o_cpu_clock      <= 1'b0;
		end else begin
			frame_cnt        <= next_frame_cnt;
			cpu_cnt          <= next_cpu_cnt;
			o_frame_strobe_n <= next_frame_strobe_n;
			o_frame_tick     <= next_frame_tick;
			o_cpu_clock      <= next_cpu_clock;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	logic [11:0] since_fall;
	logic        fall_seen;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			since_fall <= 12'h000;
			fall_seen  <= 1'b0;
		end else if (o_frame_tick) begin
			since_fall <= 12'h001;
			fall_seen  <= 1'b1;
		end else begin
			since_fall <= since_fall + 12'h001;
		end
	end

	property p_frame_period;
		@(posedge i_clk) disable iff (!i_arst_n)
		($fell(o_frame_strobe_n) && fall_seen) |-> (since_fall == 12'(FRAME_CYCLES));
	endproperty
	a_frame_period: assert property (p_frame_period) else $error("frame period wrong");

	property p_cpu_clock;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_cpu_clock) |=> o_cpu_clock ##1 !o_cpu_clock ##1 !o_cpu_clock ##1 o_cpu_clock;
	endproperty
	a_cpu_clock: assert property (p_cpu_clock) else $error("cpu clock not master/4");

endmodule

//--- shared/sads_pkg.sv
package sads_pkg;

	// -----------------------------------------------------------------
	// clock and frame timing
	// -----------------------------------------------------------------
	localparam int CLK_HZ        = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int FRAME_HZ      = 31_250;
	localparam int FRAME_CYCLES  = CLK_HZ / FRAME_HZ;
	// i_clk stands in for the crystal master clock; the ratio is kept
	localparam int MCLK_HZ       = 16_000_000;
	localparam int CPU_HZ        = 4_000_000;
	localparam int CPU_DIV       = MCLK_HZ / CPU_HZ;

	// -----------------------------------------------------------------
	// pulse and settling times, least times in ns
	// -----------------------------------------------------------------
	localparam int FRAME_LOW_NS    = 1000;
	localparam int STROBE_NS       = 50;
	localparam int SETTLE_LONG_NS  = 600;
	localparam int SETTLE_SHORT_NS = 200;
	localparam int OUT_SETTLE_NS   = 1000;

	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int FRAME_LOW_CYC    = ns_to_cycles(FRAME_LOW_NS);
	localparam int STROBE_CYC       = ns_to_cycles(STROBE_NS);
	localparam int SETTLE_LONG_CYC  = ns_to_cycles(SETTLE_LONG_NS);
	localparam int SETTLE_SHORT_CYC = ns_to_cycles(SETTLE_SHORT_NS);
	localparam int OUT_SETTLE_CYC   = ns_to_cycles(OUT_SETTLE_NS);

	// -----------------------------------------------------------------
	// conversion layout
	// -----------------------------------------------------------------
	localparam int          WORD_W       = 16;
	localparam int          LATCH_W      = 8;
	localparam logic [4:0]  NUM_TRIALS   = 5'h10;
	localparam logic [4:0]  PHASE_LEFT   = 5'h10;
	localparam logic [4:0]  PHASE_RIGHT  = 5'h11;
	// trials below this phase get the long settle
	localparam logic [4:0]  PHASE_SHORT  = 5'h08;
	localparam logic [15:0] WORD_ZERO    = 16'h0000;
	localparam logic [7:0]  WAIT_ZERO    = 8'h00;
	localparam logic [4:0]  PHASE_ZERO   = 5'h00;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SETUP  = 5'h02,
		ST_STROBE = 5'h04,
		ST_SETTLE = 5'h08,
		ST_DECIDE = 5'h10
	} sads_state_e;

	typedef struct packed {
		logic [WORD_W-1:0] left;
		logic [WORD_W-1:0] right;
	} sads_words_s;

	typedef struct packed {
		logic conv_latch_strobe;
		logic track_hold_ctl;
		logic left_output_gate;
		logic right_output_gate;
	} sads_pins_s;

	localparam sads_pins_s PINS_RESET = '{
		conv_latch_strobe: 1'b0,
		track_hold_ctl:    1'b1,
		left_output_gate:  1'b0,
		right_output_gate: 1'b0
	};

endpackage

//--- tb/sads_conv_model.sv
`timescale 1ns/100ps
module sads_conv_model
	import sads_pkg::*;
(
	// converter pins
	input  wire logic [WORD_W-1:0] i_bus,
	input  wire sads_pins_s        i_pins,
	// analog level presented at the track/hold input
	input  wire logic [WORD_W-1:0] i_analog,
	// comparator, channel and hold-error outputs
	output logic                   o_comparator_in,
	output logic [WORD_W-1:0]      o_left_out,
	output logic [WORD_W-1:0]      o_right_out,
	output logic                   o_hold_err
);
	// -----------------------------------------------------------------
	// latches, hold and comparator
	// -----------------------------------------------------------------
	logic [WORD_W-1:0] dac;
	logic [WORD_W-1:0] held;

	initial begin
		dac         = 16'h0000;
		held        = 16'h0000;
		o_left_out  = 16'h0000;
		o_right_out = 16'h0000;
		o_hold_err  = 1'b0;
	end

	// both 8-bit halves clock on the same edge
	always @(posedge i_pins.conv_latch_strobe) dac <= i_bus;
	// bus moving while the latch is open would corrupt the capture
	always @(i_bus) if (i_pins.conv_latch_strobe) o_hold_err = 1'b1;
	always @(negedge i_pins.track_hold_ctl) held = i_analog;
	// half-lsb offset so the held level never equals a dac level
	assign o_comparator_in = {held, 1'b1} > {dac, 1'b0};
	always @(dac or i_pins.left_output_gate) if (i_pins.left_output_gate) o_left_out = dac;
	always @(dac or i_pins.right_output_gate) if (i_pins.right_output_gate) o_right_out = dac;
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench
	import sads_pkg::*;
;
	// -----------------------------------------------------------------
	// signals and instances
	// -----------------------------------------------------------------
	logic              i_clk;
	logic              i_arst_n;
	logic              comparator_in;
	sads_words_s       out_words;
	logic [WORD_W-1:0] bus;
	sads_pins_s        pins;
	logic              frame_n;
	logic              cpu_clock;
	logic              cpu_clock_retimed;
	logic [WORD_W-1:0] sample_word;
	logic              sample_valid;
	logic [WORD_W-1:0] analog;
	logic [WORD_W-1:0] left_out;
	logic [WORD_W-1:0] right_out;
	logic              hold_err;
	int                mismatches;
	int                cmp_count;

	sads_sequencer i_sads_sequencer (
		.i_clk               (i_clk),
		.i_arst_n            (i_arst_n),
		.i_comparator_in     (comparator_in),
		.i_out_words         (out_words),
		.o_digital_audio_bus (bus),
		.o_pins              (pins),
		.o_frame_strobe_n    (frame_n),
		.o_cpu_clock         (cpu_clock),
		.o_sample_word       (sample_word),
		.o_sample_valid      (sample_valid)
	);

	sads_conv_model i_sads_conv_model (
		.i_bus           (bus),
		.i_pins          (pins),
		.i_analog        (analog),
		.o_comparator_in (comparator_in),
		.o_left_out      (left_out),
		.o_right_out     (right_out),
		.o_hold_err      (hold_err)
	);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// outside retiming flop on the master clock
	always @(posedge i_clk) cpu_clock_retimed <= cpu_clock;

	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task automatic wrap_up();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_frame(input logic lvl);
		int n;
		n = 0;
		while (frame_n !== lvl && n < 2 * FRAME_CYCLES) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 2 * FRAME_CYCLES) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_reset();
		chk("reset pins", pins, PINS_RESET);
		chk("reset bus", bus, 16'h0000);
		chk("reset frame", frame_n, 1'b1);
		chk("reset valid", sample_valid, 1'b0);
	endtask

	task automatic t_cpu_clock();
		logic [15:0] seq;
		for (int k = 0; k < 16; k++) begin
			@(negedge i_clk);
			seq[k] = cpu_clock;
			if (k > 0) begin
				chk("cpu clock retimed", cpu_clock_retimed, seq[k-1]);
			end
		end
		for (int k = 0; k < 12; k++) begin
			chk("cpu clock period", seq[k+4], seq[k]);
			chk("cpu clock half", seq[k+2], !seq[k]);
		end
	endtask

	// one whole frame watched from the strobe fall, cycle by cycle
	task automatic t_frame(input logic [15:0] an, input logic [15:0] lw, input logic [15:0] rw);
		int          rise[18];
		int          ns;
		int          low;
		int          th_f;
		int          th_r;
		int          vat;
		int          lg_r;
		int          rg_r;
		logic        pst;
		logic        lg17;
		logic [15:0] sw;
		ns = 0;
		low = 1;
		th_f = -1;
		th_r = -1;
		vat = -2;
		lg_r = -1;
		rg_r = -1;
		lg17 = 1'b1;
		sw = 16'h0000;
		wait_frame(1'b1);
		analog = an;
		out_words = '{left: lw, right: rw};
		wait_frame(1'b0);
		pst = pins.conv_latch_strobe;
		for (int n = 1; n <= FRAME_CYCLES; n++) begin
			@(negedge i_clk);
			if (n < FRAME_CYCLES && frame_n === 1'b0) low++;
			if (pins.track_hold_ctl === 1'b0 && th_f < 0) th_f = n;
			if (pins.track_hold_ctl === 1'b1 && th_f >= 0 && th_r < 0) th_r = n;
			if (sample_valid === 1'b1) begin
				vat = n;
				sw = sample_word;
			end
			if (pins.conv_latch_strobe === 1'b1 && pst === 1'b0) begin
				if (ns < 18) rise[ns] = n;
				if (ns == 16) lg17 = pins.left_output_gate;
				ns++;
			end
			pst = pins.conv_latch_strobe;
			if (pins.left_output_gate === 1'b1 && ns >= 17 && lg_r < 0) lg_r = n;
			if (pins.right_output_gate === 1'b1 && ns >= 18 && rg_r < 0) rg_r = n;
		end
		chk("frame low", low, FRAME_LOW_CYC);
		chk("frame period", frame_n, 1'b0);
		chk("hold fall", th_f, 1);
		chk("strobe count", ns, 18);
		chk("first strobe", rise[0], 3);
		chk("long gap", rise[1] - rise[0], STROBE_CYC + SETTLE_LONG_CYC + 2);
		chk("short gap", rise[15] - rise[14], STROBE_CYC + SETTLE_SHORT_CYC + 2);
		chk("sample word", sw, an);
		chk("hold return", th_r, vat);
		chk("left gate at latch", lg17, 1'b0);
		chk("left gate late", lg_r > rise[16], 1'b1);
		chk("right gate late", rg_r > rise[17], 1'b1);
		chk("left word", left_out, lw);
		chk("right word", right_out, rw);
		chk("bus steady", hold_err, 1'b0);
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		mismatches = 0;
		cmp_count = 0;
		i_arst_n = 1'b0;
		analog = 16'h0000;
		out_words = '{left: 16'h0000, right: 16'h0000};
		repeat (3) @(negedge i_clk);
		t_reset();
		repeat (3) @(negedge i_clk);
		i_arst_n = 1'b1;
		t_cpu_clock();
		// later frames open with the right gate still high from the one before
		t_frame(16'hA5C3, 16'h1234, 16'hFEDC);
		t_frame(16'h0000, 16'hFFFF, 16'h0001);
		t_frame(16'hFFFF, 16'h8000, 16'h7FFF);
		wrap_up();
	end
endmodule
